// *** hw/stfr_consts.svh ***
/*
 * Constants of the step/temperature/queue readout block: register offsets,
 * field positions, widths and reset values.
 * Assumes it is included by bare name from the design modules.
 */
`ifndef STFR_CONSTS_SVH
`define STFR_CONSTS_SVH

// register offsets on the serial host register space
`define STFR_OFS_STEP0      8'h1E
`define STFR_OFS_STEP1      8'h1F
`define STFR_OFS_STEP2      8'h20
`define STFR_OFS_STEP3      8'h21
`define STFR_OFS_TEMP       8'h22
`define STFR_OFS_LVL_LO     8'h24
`define STFR_OFS_LVL_HI     8'h25
`define STFR_OFS_QDATA      8'h26

// reset values
`define STFR_RST_BYTE       8'h00
`define STFR_RST_STEP       32'h0000_0000
`define STFR_RST_LEVEL      14'h0000

// field positions
`define STFR_LVL_WIDTH      14
`define STFR_LVL_LO_MSB     7
`define STFR_LVL_HI_MSB     13
`define STFR_LVL_HI_LSB     8
`define STFR_LVL_HI_PAD     2'h0

// temperature code 8'h00 stands for this many degrees Celsius
`define STFR_TEMP_ZERO_C    23

`endif

// *** hw/stfr_pkg.sv ***
/*
 * Types of the step/temperature/queue readout block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package stfr_pkg;

   // one register read request from the serial front end
   typedef struct packed {
      logic       start;   // new transaction at addr
      logic       next;    // next byte of the running burst
      logic [7:0] addr;    // register offset, used with start
   } stfr_rd_req_type;

   // answer to one read request
   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } stfr_rd_ans_type;

   typedef enum logic [2:0] {
      STFR_IDLE   = 3'b001,
      STFR_BURST  = 3'b010,
      STFR_STREAM = 3'b100
   } stfr_state_type;

endpackage

// *** hw/stfr_step_hold.sv ***
/*
 * Step count view with freeze, so a four-byte read sees one coherent count.
 * Assumes step_count comes from logic on the same clock.
 */
`timescale 1ns/100ps
`include "stfr_consts.svh"

module stfr_step_hold
   import stfr_pkg::*;
(
   input  wire logic        clock,       // system clock
   input  wire logic        reset_n,     // synchronous reset, active low
   input  wire logic [31:0] step_count,  // live step count
   input  wire logic        freeze,      // lowest step byte being read
   input  wire logic        release_hold,// highest byte read or new transaction
   output logic      [31:0] step_view    // count as presented to the host
);

   logic frozen_reg;

   // freeze wins over release so a restart at byte 0 still holds
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         frozen_reg <= 1'b0;
      end else if (freeze) begin
         frozen_reg <= 1'b1;
      end else if (release_hold) begin
         frozen_reg <= 1'b0;
      end
   end

   // the value read with byte 0 is the one kept for the other three bytes
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         step_view <= `STFR_RST_STEP;
      end else if (!frozen_reg && !freeze) begin
         step_view <= step_count;
      end
   end

endmodule

// *** hw/stfr_queue_level.sv ***
/*
 * Byte count of the data queue, raised by the fill logic, lowered by reads.
 * Assumes push comes from the queue fill logic on the same clock.
 */
`timescale 1ns/100ps
`include "stfr_consts.svh"

module stfr_queue_level
   import stfr_pkg::*;
#(
   parameter int LVL_W = `STFR_LVL_WIDTH
)
(
   input  wire logic             clock,     // system clock
   input  wire logic             reset_n,   // synchronous reset, active low
   input  wire logic             push,      // one byte entered the queue
   input  wire logic             pop_req,   // host read of the data port
   output logic                  pop_done,  // pop taken, level was nonzero
   output logic      [LVL_W-1:0] level      // bytes held
);

   localparam logic [LVL_W-1:0] LVL_ONE = {{(LVL_W-1){1'b0}}, 1'b1};
   localparam logic [LVL_W-1:0] LVL_MAX = {LVL_W{1'b1}};

   logic push_ok;

   // an empty queue is never popped, a full count is never passed
   assign pop_done = pop_req && (level != '0);
   assign push_ok  = push && (level != LVL_MAX);

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         level <= `STFR_RST_LEVEL;
      end else if (push_ok && !pop_done) begin
         level <= level + LVL_ONE;
      end else if (pop_done && !push_ok) begin
         level <= level - LVL_ONE;
      end
   end

endmodule

// *** hw/stfr_readout.sv ***
/*
 * Read-only register block: step count bytes, die temperature, queue byte
 * count and the queue read port, behind the serial host register port.
 * Assumes the serial front end, step logic, temperature sampler and queue
 * storage all run on the same clock; queue storage advances its head byte
 * at the edge that ends a cycle with queue_pop high.
 */
`timescale 1ns/100ps
`include "stfr_consts.svh"

module stfr_readout
   import stfr_pkg::*;
#(
   parameter int LVL_W = `STFR_LVL_WIDTH
)
(
   input  wire logic            clock,        // 200 MHz system clock
   input  wire logic            reset_n,      // synchronous reset, active low
   input  wire stfr_rd_req_type rd_req,       // register read request
   output stfr_rd_ans_type      rd_ans,       // read answer, one cycle later
   input  wire logic     [31:0] step_count,   // live step count
   input  wire logic      [7:0] temp_sample,  // signed kelvin offset from 23 C
   input  wire logic            temp_valid,   // temp_sample is new
   input  wire logic            queue_push,   // one byte entered the queue
   input  wire logic      [7:0] queue_head,   // oldest byte in the queue
   output logic                 queue_pop,    // head byte consumed
   output logic                 empty_read,   // data port read with no data
   output logic      [LVL_W-1:0] queue_level  // bytes held in the queue
);

   stfr_state_type  state_reg;
   stfr_state_type  state_next;
   logic      [7:0] ptr_reg;
   logic      [7:0] temp_reg;
   stfr_rd_ans_type ans_reg;
   logic            pop_reg;
   logic            empty_reg;

   logic            req_take;
   logic            req_go;
   logic      [7:0] eff_addr;
   logic      [7:0] rd_byte;
   logic      [7:0] step_byte [4];
   logic     [31:0] step_view;
   logic            step_freeze;
   logic            step_release;
   logic            q_read;
   logic            q_pop_done;
   logic [LVL_W-1:0] level;
   logic     [15:0] level_wide;

   // address walk

   // a request in the cycle the pop is out is dropped: the head byte of the
   // queue is not yet fresh, and the serial side is far slower anyway
   assign req_take = !pop_reg;

   // next is meaningful only inside a running transaction
   assign req_go = req_take &&
                   (rd_req.start || (rd_req.next && (state_reg != STFR_IDLE)));

   // bursts auto-increment, except on the data port, which streams in place
   always_comb begin
      if (rd_req.start) begin
         eff_addr = rd_req.addr;
      end else if (state_reg == STFR_STREAM) begin
         eff_addr = ptr_reg;
      end else begin
         eff_addr = ptr_reg + 8'h01;
      end
   end

   always_comb begin
      state_next = state_reg;
      if (req_go) begin
         if (eff_addr == `STFR_OFS_QDATA) begin
            state_next = STFR_STREAM;
         end else begin
            state_next = STFR_BURST;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         state_reg <= STFR_IDLE;
      end else begin
         case (state_reg)
            STFR_IDLE:   state_reg <= state_next;
            STFR_BURST:  state_reg <= state_next;
            STFR_STREAM: state_reg <= state_next;
            default:     state_reg <= STFR_IDLE;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         ptr_reg <= `STFR_RST_BYTE;
      end else if (req_go) begin
         ptr_reg <= eff_addr;
      end
   end

   // step count

   // freeze at byte 0, release at byte 3 or at any fresh transaction
   assign step_freeze  = req_go && (eff_addr == `STFR_OFS_STEP0);
   assign step_release = req_go && ((eff_addr == `STFR_OFS_STEP3) || rd_req.start);

   stfr_step_hold u_step_hold (
      .clock        (clock),
      .reset_n      (reset_n),
      .step_count   (step_count),
      .freeze       (step_freeze),
      .release_hold (step_release),
      .step_view    (step_view)
   );

   // byte k at offset step0+k holds bits 8k+7..8k
   generate
      for (genvar k = 0; k < 4; k++) begin : g_step
         assign step_byte[k] = step_view[8*k +: 8];
      end
   endgenerate

   // temperature

   // code passed through unchanged: signed kelvin steps around 23 C,
   // reset code 8'h00 therefore reads as 23 C until the first sample
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         temp_reg <= `STFR_RST_BYTE;
      end else if (temp_valid) begin
         temp_reg <= temp_sample;
      end
   end

   // queue

   assign q_read = req_go && (eff_addr == `STFR_OFS_QDATA);

   stfr_queue_level #(
      .LVL_W (LVL_W)
   ) u_queue_level (
      .clock    (clock),
      .reset_n  (reset_n),
      .push     (queue_push),
      .pop_req  (q_read),
      .pop_done (q_pop_done),
      .level    (level)
   );

   // widen to two bytes, unused high bits read as zero
   assign level_wide = {{(16 - LVL_W){1'b0}}, level};

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         pop_reg <= 1'b0;
      end else begin
         pop_reg <= q_pop_done;
      end
   end

   // reading past the count is a host fault; flagged, nothing popped
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         empty_reg <= 1'b0;
      end else begin
         empty_reg <= q_read && !q_pop_done;
      end
   end

   // read decode

   always_comb begin
      case (eff_addr)
         `STFR_OFS_STEP0:  rd_byte = step_byte[0];
         `STFR_OFS_STEP1:  rd_byte = step_byte[1];
         `STFR_OFS_STEP2:  rd_byte = step_byte[2];
         `STFR_OFS_STEP3:  rd_byte = step_byte[3];
         `STFR_OFS_TEMP:   rd_byte = temp_reg;
         `STFR_OFS_LVL_LO: rd_byte = level_wide[`STFR_LVL_LO_MSB:0];
         `STFR_OFS_LVL_HI: rd_byte = {`STFR_LVL_HI_PAD,
                                      level_wide[`STFR_LVL_HI_MSB:`STFR_LVL_HI_LSB]};
         `STFR_OFS_QDATA:  rd_byte = q_pop_done ? queue_head : `STFR_RST_BYTE;
         default:          rd_byte = `STFR_RST_BYTE;
      endcase
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         ans_reg <= '0;
      end else begin
         ans_reg.valid <= req_go;
         ans_reg.data  <= req_go ? rd_byte : `STFR_RST_BYTE;
      end
   end

   // outputs

   assign rd_ans      = ans_reg;
   assign queue_pop   = pop_reg;
   assign empty_read  = empty_reg;
   assign queue_level = level;

endmodule

// *** hw/stfr_unused_placeholder_none.sv ***
/*
 * Intentionally left without a module; holds no logic.
 * Assumes nothing.
 */
`timescale 1ns/100ps

// *** tb/stfr_readout_sva.sv ***
/*
 * Port checker for stfr_readout.
 * Assumes it is bound to stfr_readout, one clock, level width of 14 or more.
 */
`timescale 1ns/100ps
module stfr_readout_sva
   import stfr_pkg::*;
#(
   parameter int LVL_W = 14
)
(
   input wire logic             clock,       // clock
   input wire logic             reset_n,     // reset
   input wire stfr_rd_req_type  rd_req,      // request
   input wire stfr_rd_ans_type  rd_ans,      // answer
   input wire logic       [7:0] temp_sample, // sample
   input wire logic             temp_valid,  // sample strobe
   input wire logic             queue_push,  // push
   input wire logic       [7:0] queue_head,  // head byte
   input wire logic             queue_pop,   // pop
   input wire logic             empty_read,  // empty read
   input wire logic [LVL_W-1:0] queue_level  // level
);
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   sequence s_rd(logic [7:0] a);
      rd_req.start && rd_req.addr == a && !queue_pop;
   endsequence
   property p_ans;
      rd_req.start && !queue_pop |=> rd_ans.valid;
   endproperty
   property p_quiet;
      !rd_req.start && !rd_req.next |=> !rd_ans.valid && rd_ans.data == 8'h00;
   endproperty
   property p_lo;
      s_rd(8'h24) |=> rd_ans.data == $past(queue_level[7:0]);
   endproperty
   property p_hi;
      s_rd(8'h25) |=> rd_ans.data == {2'h0, $past(queue_level[13:8])};
   endproperty
   // sample loaded, one quiet cycle, then the read of the register
   sequence s_load;
      temp_valid ##1 !temp_valid;
   endsequence
   property p_temp;
      s_load ##1 (s_rd(8'h22) ##0 !temp_valid) |=> rd_ans.data == $past(temp_sample, 3);
   endproperty
   property p_pop;
      s_rd(8'h26) ##0 queue_level != 0 |=> queue_pop && rd_ans.data == $past(queue_head);
   endproperty
   property p_dec;
      s_rd(8'h26) ##0 (queue_level != 0 && !queue_push)
         |=> queue_level == $past(queue_level) - 1'b1;
   endproperty
   property p_empty;
      s_rd(8'h26) ##0 queue_level == 0 |=> empty_read && !queue_pop && rd_ans.data == 8'h00;
   endproperty
   property p_pulse;
      queue_pop |=> !queue_pop && !rd_ans.valid;
   endproperty
   a_ans: assert property (p_ans) else $error("no answer");
   a_quiet: assert property (p_quiet) else $error("stray answer");
   a_lo: assert property (p_lo) else $error("level low");
   a_hi: assert property (p_hi) else $error("level high");
   a_temp: assert property (p_temp) else $error("temperature");
   a_pop: assert property (p_pop) else $error("data port");
   a_dec: assert property (p_dec) else $error("level drop");
   a_empty: assert property (p_empty) else $error("empty read");
   a_pulse: assert property (p_pulse) else $error("pop pulse");
endmodule

bind stfr_readout stfr_readout_sva #(.LVL_W(LVL_W)) i_sva (.clock, .reset_n, .rd_req,
   .rd_ans, .temp_sample, .temp_valid, .queue_push, .queue_head, .queue_pop, .empty_read,
   .queue_level);

// *** tb/stfr_queue_model.sv ***
/*
 * Behavioural queue storage feeding the head byte.
 * Assumes push and pop on the system clock.
 */
`timescale 1ns/100ps
module stfr_queue_model (
   input  wire logic       clock,     // clock
   input  wire logic       reset_n,   // reset
   input  wire logic       push,      // store push_data
   input  wire logic [7:0] push_data, // byte in
   input  wire logic       pop,       // drop head
   output logic      [7:0] head       // oldest byte
);
   logic [7:0] mem_q[$];
   logic [7:0] junk_reg;
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         junk_reg <= 8'hA5;
         mem_q.delete();
      end else begin
         junk_reg <= ~junk_reg + 8'h01;
         if (pop && mem_q.size() > 0) void'(mem_q.pop_front());
         if (push) mem_q.push_back(push_data);
      end
   end
   // empty: garbage that moves, never a stale byte
   always_comb head = (mem_q.size() > 0) ? mem_q[0] : junk_reg;
endmodule

// *** tb/stfr_readout_bench.sv ***
/*
 * Self-checking bench of stfr_readout with a queue storage model.
 * Assumes the design and model files are compiled first.
 */
`timescale 1ns/100ps
`include "stfr_consts.svh"
module stfr_readout_bench
   import stfr_pkg::*;
;
   logic            clock;
   logic            reset_n;
   stfr_rd_req_type rd_req;
   stfr_rd_ans_type rd_ans;
   logic     [31:0] step_count;
   logic      [7:0] temp_sample;
   logic            temp_valid;
   logic            queue_push;
   logic      [7:0] push_data;
   logic      [7:0] queue_head;
   logic            queue_pop;
   logic            empty_read;
   logic     [13:0] queue_level;
   int              num_errors;
   int              total_checks;
   logic      [7:0] exp_q[$];
   logic      [7:0] regs[9] = '{8'h1E, 8'h1F, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26};
   int              temps[5] = '{23, 150, -105, 22, 0};

   stfr_readout #(.LVL_W(14)) i_dut (.clock, .reset_n, .rd_req, .rd_ans, .step_count,
      .temp_sample, .temp_valid, .queue_push, .queue_head, .queue_pop, .empty_read,
      .queue_level);
   stfr_queue_model i_queue (.clock, .reset_n, .push(queue_push), .push_data,
      .pop(queue_pop), .head(queue_head));

   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   function automatic logic [7:0] t_code(input int c);
      return 8'(c - `STFR_TEMP_ZERO_C);
   endfunction

   task automatic chk(input logic [8:0] got, input logic [8:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   // whole 14-bit level straight off the output port
   task automatic chk_level(input int want);
      chk({1'b0, queue_level[7:0]}, {1'b0, 8'(want)});
      chk({3'h0, queue_level[13:8]}, {3'h0, 6'(want >> 8)});
   endtask

   // nx selects a burst continuation instead of a new transaction
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic nx = 1'b0);
      @(posedge clock);
      rd_req <= '{start: !nx, next: nx, addr: a};
      @(posedge clock);
      rd_req <= '0;
      #1;
      chk({rd_ans.valid, rd_ans.data}, {1'b1, e});
   endtask

   task automatic end_of_test;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   initial begin
      repeat (100000) @(posedge clock);
      num_errors++;
      end_of_test();
   end

   initial begin
      logic [31:0] s;
      int          n;
      logic [7:0]  b;
      rd_req = '0;
      step_count = '0;
      temp_sample = '0;
      temp_valid = 1'b0;
      queue_push = 1'b0;
      push_data = '0;
      reset_n = 1'b0;
      void'($urandom(43));
      repeat (8) @(posedge clock);
      reset_n <= 1'b1;
      foreach (regs[i]) rd(regs[i], 8'h00);
      s = $urandom;
      @(posedge clock) step_count <= s;
      rd(8'h1E, s[7:0]);
      @(posedge clock) step_count <= ~s;
      rd(8'h00, s[15:8], 1'b1);
      rd(8'h00, s[23:16], 1'b1);
      rd(8'h00, s[31:24], 1'b1);
      temps[4] = $urandom_range(60) - 20;
      foreach (temps[i]) begin
         @(posedge clock);
         temp_sample <= t_code(temps[i]);
         temp_valid <= 1'b1;
         @(posedge clock);
         temp_valid <= 1'b0;
         rd(8'h22, t_code(temps[i]));
      end
      n = 256 + $urandom_range(40);
      repeat (n) begin
         @(posedge clock);
         b = 8'($urandom);
         queue_push <= 1'b1;
         push_data <= b;
         exp_q.push_back(b);
      end
      @(posedge clock) queue_push <= 1'b0;
      #1;
      chk_level(n);
      rd(8'h24, n[7:0]);
      rd(8'h25, {2'h0, n[13:8]});
      rd(8'h26, exp_q.pop_front());
      // request held into the pop cycle: refused, only one byte popped
      @(posedge clock) rd_req <= '{start: 1'b1, next: 1'b0, addr: 8'h26};
      @(posedge clock);
      #1;
      chk({rd_ans.valid, rd_ans.data}, {1'b1, exp_q.pop_front()});
      @(posedge clock) rd_req <= '0;
      #1;
      chk({rd_ans.valid, queue_pop, 7'h00}, 9'h000);
      chk_level(n - 2);
      repeat (n - 3) rd(8'h00, exp_q.pop_front(), 1'b1);
      rd(8'h24, 8'h01);
      rd(8'h26, exp_q.pop_front());
      rd(8'h24, 8'h00);
      rd(8'h25, 8'h00);
      rd(8'h26, 8'h00);
      chk({7'h00, queue_pop, empty_read}, 9'h001);
      chk_level(0);
      // mid-run reset with a byte queued and the step view frozen
      @(posedge clock) queue_push <= 1'b1;
      @(posedge clock) queue_push <= 1'b0;
      rd(8'h1E, ~s[7:0]);
      @(posedge clock) reset_n <= 1'b0;
      step_count <= '0;
      repeat (2) @(posedge clock);
      reset_n <= 1'b1;
      foreach (regs[i]) rd(regs[i], 8'h00);
      end_of_test();
   end
endmodule
